/* File: include/rtc_pkg.sv */
// constants for the clock status, interrupt, square-wave and ram-clear block
`default_nettype none
package rtc_pkg;
  // clock rates
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned OSC_HZ      = 32_768;
  localparam int unsigned ACC_W       = 25;
  localparam int unsigned DIV_STAGES  = 15;
  // byte map
  localparam int unsigned MAP_BYTES   = 128;
  localparam int unsigned TIME_BYTES  = 10;
  localparam int unsigned REG_BYTES   = 14;
  localparam int unsigned GP_BYTES    = 114;
  localparam logic [6:0]  IDX_REG_A   = 7'h0A;
  localparam logic [6:0]  IDX_REG_B   = 7'h0B;
  localparam logic [6:0]  IDX_REG_C   = 7'h0C;
  localparam logic [6:0]  IDX_REG_D   = 7'h0D;
  // register A fields
  localparam int unsigned A_UIP       = 7;
  localparam int unsigned A_DV_LSB    = 4;
  localparam logic [2:0]  DV_RUN      = 3'h2;
  localparam logic [6:0]  REG_A_RST   = 7'h20;
  // register B fields
  localparam int unsigned B_SET       = 7;
  localparam int unsigned B_PIE       = 6;
  localparam int unsigned B_AIE       = 5;
  localparam int unsigned B_UIE       = 4;
  localparam int unsigned B_SQUARE_WAVE_ENABLE      = 3;
  localparam int unsigned B_HR24      = 1;
  localparam logic [7:0]  REG_B_RST   = 8'h02;
  // register C and D
  localparam int unsigned C_FLAG_LSB  = 4;
  localparam logic [7:0]  REG_D_VAL   = 8'h80;
  // flag vector positions {periodic, alarm, update-ended}
  localparam int unsigned FLG_PF      = 2;
  localparam int unsigned FLG_AF      = 1;
  localparam int unsigned FLG_UF      = 0;
  localparam logic [1:0]  ALARM_DC    = 2'h3;
  localparam logic [7:0]  RAM_CLEAR   = 8'hFF;
endpackage
`default_nettype wire

/* File: verilog/rtc_core.sv */
// clock status, interrupt, square-wave, ram-clear and apb access logic
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module rtc_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        device_reset_n,
  input  wire logic        above_power_fail_trip_point,
  input  wire logic        general_ram_clear_n,
  output var  logic        irq_n_o,
  output var  logic        irq_n_oe,
  output var  logic        square_wave_out
);

  // pin synchronisers: bit 2 ram clear, bit 1 reset pin, bit 0 power good
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic        pwr_ok;
  logic        pin_rst_n;
  logic        clr_n;

  // oscillator and divider chain
  logic [rtc_pkg::ACC_W-1:0]      acc;
  logic [rtc_pkg::ACC_W-1:0]      next_acc;
  logic [rtc_pkg::DIV_STAGES-1:0] div_cnt;
  logic [rtc_pkg::DIV_STAGES-1:0] next_div_cnt;
  logic                           osc_run;
  logic                           osc_tick;
  logic                           tap;
  logic                           tap_prev;
  logic                           uip;

  // control and status
  logic [6:0]  reg_a;
  logic [6:0]  next_reg_a;
  logic [7:0]  reg_b;
  logic [7:0]  next_reg_b;
  logic [2:0]  flags;
  logic [2:0]  next_flags;
  logic [2:0]  c_seen;
  logic [2:0]  next_c_seen;
  logic [2:0]  ens;
  logic        interrupt_summary_flag;
  logic        per_evt;
  logic        upd_evt;
  logic        alm_evt;
  logic        alarm_hit;
  logic        pin_rst_act;
  logic        refuse;
  logic        clr_act;

  // bus
  logic [6:0]  idx;
  logic        done;
  logic        wr_ok;
  logic        rd_ok;
  logic [7:0]  rd_byte;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq_oe;
  logic        next_sqw;

  // byte store for time bytes and general ram
  logic [7:0]  mem [0:rtc_pkg::MAP_BYTES-1];

  // two flops on every pin; idle ram-clear reads high
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 3'h6;
      sync2 <= 3'h6;
    end else begin
      sync1 <= {general_ram_clear_n, device_reset_n, above_power_fail_trip_point};
      sync2 <= sync1;
    end
  end

  assign clr_n       = sync2[2];
  assign pin_rst_n   = sync2[1];
  assign pwr_ok      = sync2[0];
  assign pin_rst_act = !pin_rst_n && pwr_ok;
  assign refuse      = !pwr_ok || !pin_rst_n;
  assign clr_act     = !clr_n && !pwr_ok;

  // fractional prescaler gives an average 32.768 khz tick
  assign osc_run  = (reg_a[rtc_pkg::A_DV_LSB +: 3] == rtc_pkg::DV_RUN);
  assign osc_tick = osc_run &&
                    ({1'b0, acc} + rtc_pkg::OSC_HZ[rtc_pkg::ACC_W:0] >= rtc_pkg::CLK_HZ[rtc_pkg::ACC_W:0]);

  always_comb begin
    next_acc     = acc;
    next_div_cnt = div_cnt;
    // divider moves one count per oscillator tick, frozen while stopped
    if (osc_run) begin
      if (osc_tick) begin
        next_acc     = acc + rtc_pkg::OSC_HZ[rtc_pkg::ACC_W-1:0] - rtc_pkg::CLK_HZ[rtc_pkg::ACC_W-1:0];
        next_div_cnt = div_cnt + {{(rtc_pkg::DIV_STAGES-1){1'b0}}, 1'b1};
      end else begin
        next_acc = acc + rtc_pkg::OSC_HZ[rtc_pkg::ACC_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc      <= '0;
      div_cnt  <= '0;
      tap_prev <= 1'b0;
    end else begin
      acc      <= next_acc;
      div_cnt  <= next_div_cnt;
      tap_prev <= tap;
    end
  end

  // rate select: 1,2 give 256/128 hz, 3..15 give 8192 hz down to 2 hz
  always_comb begin
    case (reg_a[3:0])
      4'h0:    tap = 1'b0;
      4'h1:    tap = div_cnt[6];
      4'h2:    tap = div_cnt[7];
      default: tap = div_cnt[reg_a[3:0] - 4'h2];
    endcase
  end

  assign per_evt = tap && !tap_prev;
  assign uip     = &div_cnt[rtc_pkg::DIV_STAGES-1:3];
  assign upd_evt = osc_tick && (&div_cnt) && !reg_b[rtc_pkg::B_SET];

  // alarm compares seconds, minutes, hours with don't-care codes
  always_comb begin
    alarm_hit = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (mem[2*k+1][7:6] != rtc_pkg::ALARM_DC && mem[2*k+1] != mem[2*k]) begin
        alarm_hit = 1'b0;
      end
    end
  end

  assign alm_evt = upd_evt && alarm_hit;

  // summary: or of the three flag and enable pairs
  assign ens  = {reg_b[rtc_pkg::B_PIE], reg_b[rtc_pkg::B_AIE], reg_b[rtc_pkg::B_UIE]};
  assign interrupt_summary_flag = |(flags & ens);

  // apb access: pready one cycle into the access phase
  assign idx   = paddr[8:2];
  assign done  = psel && penable && pready;
  assign wr_ok = done && pwrite && !pslverr;
  assign rd_ok = done && !pwrite && !pslverr;

  // read mux over the 128-byte map
  always_comb begin
    case (idx)
      rtc_pkg::IDX_REG_A: rd_byte = {uip, reg_a};
      rtc_pkg::IDX_REG_B: rd_byte = reg_b;
      rtc_pkg::IDX_REG_C: rd_byte = {interrupt_summary_flag, flags, 4'h0};
      rtc_pkg::IDX_REG_D: rd_byte = rtc_pkg::REG_D_VAL;
      default:            rd_byte = mem[idx];
    endcase
  end

  // bus answer; the byte-wide multiplexed strobes of either style fold onto apb
  always_comb begin
    next_pready  = 1'b0;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    next_c_seen  = c_seen;
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = refuse || (paddr[11:9] != 3'h0);
      next_prdata  = {24'h0000_00, rd_byte};
      if (idx == rtc_pkg::IDX_REG_C) begin
        next_c_seen = flags;
      end
    end
  end

  // control registers and sticky flags; a new event wins over the read clear
  always_comb begin
    next_reg_a = reg_a;
    next_reg_b = reg_b;
    next_flags = flags;
    if (wr_ok && idx == rtc_pkg::IDX_REG_A) begin
      next_reg_a = pwdata[6:0];
    end
    if (wr_ok && idx == rtc_pkg::IDX_REG_B) begin
      next_reg_b = pwdata[7:0];  // hour format bit kept for the calendar
    end
    if (rd_ok && idx == rtc_pkg::IDX_REG_C) begin
      next_flags = flags & ~c_seen;
    end
    next_flags[rtc_pkg::FLG_PF] = next_flags[rtc_pkg::FLG_PF] | per_evt;
    next_flags[rtc_pkg::FLG_AF] = next_flags[rtc_pkg::FLG_AF] | alm_evt;
    next_flags[rtc_pkg::FLG_UF] = next_flags[rtc_pkg::FLG_UF] | upd_evt;
    if (pin_rst_act) begin
      next_flags                  = 3'h0;
      next_reg_b[rtc_pkg::B_PIE]  = 1'b0;
      next_reg_b[rtc_pkg::B_AIE]  = 1'b0;
      next_reg_b[rtc_pkg::B_UIE]  = 1'b0;
      next_reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] = 1'b0;
    end
  end

  // registering from next values keeps the line in step with the flags
  // output pins: line enable follows the next summary, square wave gated
  always_comb begin
    next_irq_oe = |(next_flags & {next_reg_b[rtc_pkg::B_PIE], next_reg_b[rtc_pkg::B_AIE],
                                  next_reg_b[rtc_pkg::B_UIE]});
    next_sqw    = tap && reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] && pwr_ok;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_a           <= rtc_pkg::REG_A_RST;
      reg_b           <= rtc_pkg::REG_B_RST;
      flags           <= 3'h0;
      c_seen          <= 3'h0;
      pready          <= 1'b0;
      prdata          <= 32'h0000_0000;
      pslverr         <= 1'b0;
      irq_n_o         <= 1'b0;
      irq_n_oe        <= 1'b0;
      square_wave_out <= 1'b0;
    end else begin
      reg_a           <= next_reg_a;
      reg_b           <= next_reg_b;
      flags           <= next_flags;
      c_seen          <= next_c_seen;
      pready          <= next_pready;
      prdata          <= next_prdata;
      pslverr         <= next_pslverr;
      irq_n_o         <= 1'b0;         // only ever drives low
      irq_n_oe        <= next_irq_oe;  // released when idle
      square_wave_out <= next_sqw;
    end
  end

  // byte store: time bytes written by the host, general ram also cleared
  for (genvar g = 0; g < rtc_pkg::MAP_BYTES; g++) begin : g_mem
    if (g < rtc_pkg::TIME_BYTES || g >= rtc_pkg::REG_BYTES) begin : g_used
      logic [7:0] next_byte;
      always_comb begin
        next_byte = mem[g];
        if (clr_act && g >= rtc_pkg::REG_BYTES) begin
          next_byte = rtc_pkg::RAM_CLEAR;
        end else if (wr_ok && idx == 7'(g)) begin
          next_byte = pwdata[7:0];
        end
      end
      always_ff @(posedge clk) begin
        mem[g] <= next_byte;
      end
    end else begin : g_ctl
      // control indices live in their own registers
      assign mem[g] = 8'h00;
    end
  end

  // checks: periodic pair drives the line
  // a status read or a write to B in the same cycle may legally drop it
  irq_drive_a: assert property (@(posedge clk) disable iff (rst)
    (flags[rtc_pkg::FLG_PF] && reg_b[rtc_pkg::B_PIE] && !pin_rst_act &&
     !(rd_ok && idx == rtc_pkg::IDX_REG_C) && !(wr_ok && idx == rtc_pkg::IDX_REG_B))
      |=> irq_n_oe)
    else $error("interrupt line not driven for periodic flag");

  // line enable matches the registered flag and enable pairs
  irq_pairs_a: assert property (@(posedge clk) disable iff (rst)
    irq_n_oe == interrupt_summary_flag)
    else $error("interrupt line differs from the flag and enable pairs");

  // status read clears what it returned
  // a fresh event in the same cycle survives, so it is left out
  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    (rd_ok && idx == rtc_pkg::IDX_REG_C && !per_evt && !upd_evt && !pin_rst_act)
      |=> (flags == ($past(flags) & ~$past(c_seen))))
    else $error("status read did not clear the flags it returned");

  // reading every pending flag releases the line
  irq_release_a: assert property (@(posedge clk) disable iff (rst)
    (rd_ok && idx == rtc_pkg::IDX_REG_C && c_seen == flags && !per_evt && !upd_evt && !pin_rst_act)
      |=> !irq_n_oe)
    else $error("interrupt line still driven after the status read");

  // periodic flag stays set until read or cleared by the reset pin
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    (flags[rtc_pkg::FLG_PF] && !(rd_ok && idx == rtc_pkg::IDX_REG_C) && !pin_rst_act)
      |=> flags[rtc_pkg::FLG_PF])
    else $error("periodic flag dropped without a status read");

  // reset pin clears enables and flags, line released after
  // enables held clear every cycle while the pin stays low and power is good
  pin_reset_a: assert property (@(posedge clk) disable iff (rst)
    pin_rst_act |=> (flags == 3'h0 && !reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] && ens == 3'h0) ##1 !irq_n_oe)
    else $error("reset pin did not clear enables, flags and line");

  // open drain data never high
  // releasing the line is done by the enable alone
  open_drain_a: assert property (@(posedge clk) disable iff (rst)
    !irq_n_o)
    else $error("interrupt pin driven high");

  // ram clear fills general ram, time bytes kept
  // a write landing in the same cycle is left out
  ram_clear_a: assert property (@(posedge clk) disable iff (rst)
    (clr_act && !wr_ok) |=> (mem[rtc_pkg::REG_BYTES] == rtc_pkg::RAM_CLEAR &&
      mem[rtc_pkg::MAP_BYTES-1] == rtc_pkg::RAM_CLEAR && $stable(mem[0])))
    else $error("ram clear missed ram or disturbed a time byte");

  // square wave off while disabled or on low power
  sqw_gate_a: assert property (@(posedge clk) disable iff (rst)
    (!reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] || !pwr_ok) |=> !square_wave_out)
    else $error("square wave present while disabled or power low");

  // enabled square wave follows the selected tap
  // one register stage between tap and pin
  sqw_source_a: assert property (@(posedge clk) disable iff (rst)
    (reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE] && pwr_ok) |=> (square_wave_out == $past(tap)))
    else $error("square wave does not follow the selected tap");

  // rising tap sets the periodic flag
  periodic_set_a: assert property (@(posedge clk) disable iff (rst)
    (per_evt && !pin_rst_act) |=> flags[rtc_pkg::FLG_PF])
    else $error("periodic event did not set its flag");

  // refused accesses answer with an error
  access_block_a: assert property (@(posedge clk) disable iff (rst)
    (psel && penable && !pready && refuse) |=> (pready && pslverr))
    else $error("access accepted while power low or reset pin low");

  // refused writes leave the control registers alone
  // the reset pin itself may still clear register B
  write_refused_a: assert property (@(posedge clk) disable iff (rst)
    (done && pwrite && pslverr && !pin_rst_act) |=> ($stable(reg_a) && $stable(reg_b)))
    else $error("refused write changed a control register");

  // stopped oscillator freezes the divider
  // only the cycle after is checked, a restart may follow at once
  osc_stop_a: assert property (@(posedge clk) disable iff (rst)
    !osc_run |=> $stable(div_cnt))
    else $error("divider advanced with oscillator stopped");

  // answer exactly one cycle into the access phase
  // pready stands one cycle only
  slave_ready_a: assert property (@(posedge clk) disable iff (rst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle into access phase");

  // byte-wide map: upper read lanes stay zero
  prdata_upper_a: assert property (@(posedge clk) disable iff (rst)
    pready |-> (prdata[31:8] == 24'h00_0000))
    else $error("read data upper lanes not zero");

  // main scenarios
  // status read, ram clear, periodic interrupt, stopped oscillator, refusal
  status_read_c: cover property (@(posedge clk) disable iff (rst)
    rd_ok && idx == rtc_pkg::IDX_REG_C && c_seen != 3'h0);
  ram_clear_c: cover property (@(posedge clk) disable iff (rst) clr_act);
  periodic_irq_c: cover property (@(posedge clk) disable iff (rst)
    per_evt && reg_b[rtc_pkg::B_PIE] ##1 irq_n_oe);
  osc_stop_c: cover property (@(posedge clk) disable iff (rst)
    !osc_run && reg_b[rtc_pkg::B_SQUARE_WAVE_ENABLE]);
  refused_c: cover property (@(posedge clk) disable iff (rst)
    done && pslverr && refuse);

endmodule
`default_nettype wire

/* File: testbench/rtc_host_model.sv */
// host processor model: apb master issuing single byte transfers
`default_nettype none
module rtc_host (
  input  wire logic        clk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // setup, access, hold until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/rtc_irq_sqw_ramclear_access_test.sv */
// self-checking bench for the rtc status, interrupt, square-wave and ram-clear block
`default_nettype none
module rtc_irq_sqw_ramclear_access_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, dev_rst_n, pwr_ok, general_ram_clear_n;
  logic        psel, penable, pwrite, pready, pslverr, irq_n_o, irq_n_oe, sqw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rd;
  logic        er;
  int          bad_count, n_compared, k;
  wire         irq_line = irq_n_oe ? irq_n_o : 1'b1;  // external pull-up
  rtc_core dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_reset_n(dev_rst_n),
    .above_power_fail_trip_point(pwr_ok), .general_ram_clear_n(general_ram_clear_n),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .square_wave_out(sqw));
  rtc_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ee);
    host.xfer(1'b1, a, d, rd, er);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  // refused reads only check the error flag
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] d, input logic ee);
    host.xfer(1'b0, a, 8'h00, rd, er);
    chk({23'h0, er, ee ? 8'h00 : rd}, {23'h0, ee, ee ? 8'h00 : d});
  endtask
  task automatic rises(input int n, output int r);
    logic p;
    p = sqw;
    r = 0;
    repeat (n) begin
      @(posedge clk);
      if (sqw === 1'b1 && p === 1'b0) r++;
      p = sqw;
    end
  endtask
  task automatic wait_irq();
    k = 0;
    while (irq_n_oe !== 1'b1 && k < 4000) begin
      cyc(1);
      k++;
    end
  endtask
  // watchdog
  initial begin
    #(40 * 80000);
    bad_count++;
    conclude();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    dev_rst_n = 1'b1;
    pwr_ok = 1'b1;
    general_ram_clear_n = 1'b1;  // pin idles high through its pull-up
    bad_count = 0;
    n_compared = 0;
    cyc(16);
    rst <= 1'b0;
    cyc(6);
    rd_chk(12'h028, 8'h20, 1'b0);
    rd_chk(12'h02C, 8'h02, 1'b0);
    rd_chk(12'h034, 8'h80, 1'b0);
    wr(12'h038, 8'h5A, 1'b0);
    rd_chk(12'h038, 8'h5A, 1'b0);
    wr(12'h1FC, 8'hC3, 1'b0);
    rd_chk(12'h1FC, 8'hC3, 1'b0);
    rd_chk(12'h200, 8'h00, 1'b1);
    wr(12'h000, 8'h12, 1'b0);
    wr(12'h028, 8'h23, 1'b0);
    wr(12'h02C, 8'h4A, 1'b0);
    wait_irq();
    chk({31'h0, irq_line}, 32'h0);
    rd_chk(12'h030, 8'hC0, 1'b0);
    cyc(2);
    chk({31'h0, irq_n_oe}, 32'h0);
    chk({31'h0, irq_line}, 32'h1);
    rises(12208, k);
    chk({31'h0, k >= 3 && k <= 5}, 32'h1);
    wr(12'h028, 8'h24, 1'b0);
    rises(12208, k);
    chk({31'h0, k >= 1 && k <= 3}, 32'h1);
    wr(12'h028, 8'h20, 1'b0);
    rises(4000, k);
    chk(k, 32'h0);
    wr(12'h028, 8'h03, 1'b0);
    rd_chk(12'h028, 8'h03, 1'b0);
    rises(4000, k);
    chk(k, 32'h0);
    wr(12'h028, 8'h23, 1'b0);
    wr(12'h02C, 8'h02, 1'b0);
    rises(4000, k);
    chk(k, 32'h0);
    wr(12'h02C, 8'h0A, 1'b0);
    rd_chk(12'h030, 8'h40, 1'b0);
    cyc(4000);
    chk({31'h0, irq_n_oe}, 32'h0);
    rd_chk(12'h030, 8'h40, 1'b0);
    pwr_ok <= 1'b0;
    cyc(6);
    rd_chk(12'h02C, 8'h00, 1'b1);
    wr(12'h038, 8'h00, 1'b1);
    rises(4000, k);
    chk(k, 32'h0);
    general_ram_clear_n <= 1'b0;  // grounded while on backup power
    cyc(6);
    general_ram_clear_n <= 1'b1;
    pwr_ok <= 1'b1;
    cyc(6);
    rd_chk(12'h038, 8'hFF, 1'b0);
    rd_chk(12'h1FC, 8'hFF, 1'b0);
    rd_chk(12'h000, 8'h12, 1'b0);
    wr(12'h038, 8'h5A, 1'b0);
    general_ram_clear_n <= 1'b0;
    cyc(6);
    general_ram_clear_n <= 1'b1;
    rd_chk(12'h038, 8'h5A, 1'b0);
    wr(12'h02C, 8'h4A, 1'b0);
    wait_irq();
    chk({31'h0, irq_n_oe}, 32'h1);
    dev_rst_n <= 1'b0;
    cyc(4);
    chk({31'h0, irq_n_oe}, 32'h0);
    rd_chk(12'h02C, 8'h00, 1'b1);
    dev_rst_n <= 1'b1;
    cyc(4);
    rd_chk(12'h02C, 8'h02, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
